/* src/xip_exit_and_powerup_control.sv */
`timescale 1ns/1ps
`default_nettype none
module xip_exit_and_powerup_control #(
  parameter int unsigned PWRUP_CYCLES = xip_pkg::PWRUP_CYC
) (
  input  wire logic            REF_CLK_I,
  input  wire logic            RST_I,
  input  wire logic            POR_I,
  input  wire logic            SPI_CLK_I,
  input  wire logic            CS_N_I,
  input  wire logic [3:0]      DQ_I,
  input  wire logic            HW_RST_N_I,
  input  wire xip_pkg::nvcfg_s NVCFG_I,
  input  wire logic            VCFG_WR_I,
  input  wire logic            VCFG_XIP_I,
  input  wire logic            PE_BUSY_I,
  input  wire logic            WEL_SET_I,
  input  wire logic            LOCK_WR_I,
  input  wire xip_pkg::lock_s  LOCK_I,
  output logic                 XIP_ACTIVE_O,
  output logic                 VCFG_XIP_O,
  output var  xip_pkg::proto_e PROTO_O,
  output logic                 WIP_O,
  output logic                 WEL_O,
  output var  xip_pkg::lock_s  LOCK_O,
  output logic                 FLAG_READY_O,
  output logic                 INIT_DONE_O,
  output logic                 PAUSE_EN_O,
  output logic                 HW_RST_EN_O,
  output logic [2:0]           DRIVE_O,
  output logic                 CMD_VALID_O,
  output logic [7:0]           CMD_OPCODE_O,
  output logic                 CMD_REJECT_O,
  output logic                 FORCED_EXIT_O
);
  import xip_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_INIT, ST_READY} pwr_e;

  pwr_e             state_r;
  logic [TMR_W-1:0] tmr_r;
  logic             por_s1_r;
  logic             por_s2_r;
  logic             hwr_s1_r;
  logic             hwr_s2_r;
  logic             cs_s1_r;
  logic             cs_s2_r;
  logic             cs_s3_r;
  logic             tog_s1_r;
  logic             tog_s2_r;
  logic             tog_seen_r;
  frame_s           frame;
  logic             link_tog;
  logic             rst_all;
  logic             in_init;
  logic             ev;
  logic             fx;
  logic             is_rd;
  logic             is_status;
  logic             conf_ok;
  logic             conf;
  logic             hw_go;
  logic [LEN_W-1:0] didx;
  logic [7:0]       opc;

  // ****************************************
  // link side capture
  // ****************************************
  xip_link_capture u_link (
    .spi_clk_i (SPI_CLK_I),
    .cs_n_i    (CS_N_I),
    .rst_i     (RST_I),
    .dq_i      (DQ_I),
    .frame_o   (frame),
    .tog_o     (link_tog)
  );

  // ****************************************
  // synchronisers
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      por_s1_r <= 1'b0;
      por_s2_r <= 1'b0;
      hwr_s1_r <= 1'b1;
      hwr_s2_r <= 1'b1;
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      cs_s3_r  <= 1'b1;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
    end else begin
      por_s1_r <= POR_I;
      por_s2_r <= por_s1_r;
      hwr_s1_r <= HW_RST_N_I;
      hwr_s2_r <= hwr_s1_r;
      cs_s1_r  <= CS_N_I;
      cs_s2_r  <= cs_s1_r;
      cs_s3_r  <= cs_s2_r;
      tog_s1_r <= link_tog;
      tog_s2_r <= tog_s1_r;
    end
  end

  // frames ending during power-on reset are consumed here and never acted on
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      tog_seen_r <= 1'b0;
    end else if (cs_s2_r & ~cs_s3_r) begin
      tog_seen_r <= tog_s2_r;
    end
  end

  // ****************************************
  // frame decode
  // ****************************************
  // the frame record is read only after select rose, when the link clock is idle
  assign rst_all   = RST_I | por_s2_r;
  assign in_init   = (state_r != ST_READY);
  assign ev        = cs_s2_r & ~cs_s3_r & (tog_s2_r != tog_seen_r) & (state_r != ST_OFF);
  assign fx        = frame.all_ones & is_exit_len(frame.len);
  assign opc       = XIP_ACTIVE_O ? fread_op(PROTO_O) : opcode_of(frame, PROTO_O);
  assign is_rd     = XIP_ACTIVE_O | (opc == fread_op(PROTO_O));
  assign is_status = (opc == OP_RD_STATUS) | (opc == OP_RD_FLAG);
  assign didx      = dummy_idx(PROTO_O, XIP_ACTIVE_O);
  assign conf_ok   = (frame.len > didx);
  // only lane zero is looked at; upper lanes of that cycle are don't care
  assign conf      = frame.dq[didx][DQ_CONFIRM];
  assign hw_go     = ~hwr_s2_r & HW_RST_EN_O & ((PROTO_O != PROTO_QIO) | cs_s2_r);

  // ****************************************
  // power-up sequencer
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (rst_all) begin
      state_r <= ST_OFF;
      tmr_r   <= '0;
    end else begin
      case (state_r)
        ST_OFF: begin
          state_r <= ST_INIT;
          tmr_r   <= '0;
        end
        ST_INIT: begin
          if (tmr_r == TMR_W'(PWRUP_CYCLES - 1)) begin
            state_r <= ST_READY;
          end
          tmr_r <= tmr_r + 1'b1;
        end
        ST_READY: begin
          state_r <= ST_READY;
        end
        default: begin
          state_r <= ST_OFF;
        end
      endcase
    end
  end

  // ****************************************
  // in-place mode and protocol
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (rst_all) begin
      XIP_ACTIVE_O  <= 1'b0;
      VCFG_XIP_O    <= VCFG_XIP_OFF;
      PROTO_O       <= PROTO_EXT;
      FORCED_EXIT_O <= 1'b0;
    end else begin
      FORCED_EXIT_O <= ev & fx & XIP_ACTIVE_O & ~hw_go;
      if ((state_r == ST_OFF) | hw_go) begin
        PROTO_O      <= NVCFG_I.proto;
        XIP_ACTIVE_O <= NVCFG_I.xip_boot;
        VCFG_XIP_O   <= VCFG_XIP_OFF;
      end else if (ev & fx & XIP_ACTIVE_O) begin
        // only the mode ends; sequencer and busy tracking are untouched
        XIP_ACTIVE_O <= 1'b0;
        VCFG_XIP_O   <= VCFG_XIP_OFF;
      end else if (ev & ~in_init & is_rd & conf_ok) begin
        if (conf == CONFIRM_EXIT) begin
          if (XIP_ACTIVE_O) begin
            XIP_ACTIVE_O <= 1'b0;
            VCFG_XIP_O   <= VCFG_XIP_OFF;
          end
        end else if (XIP_ACTIVE_O | (VCFG_XIP_O != VCFG_XIP_OFF)) begin
          XIP_ACTIVE_O <= 1'b1;
        end
      end else if (VCFG_WR_I) begin
        VCFG_XIP_O <= VCFG_XIP_I;
      end
    end
  end

  // ****************************************
  // command filter
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (rst_all) begin
      CMD_VALID_O  <= 1'b0;
      CMD_REJECT_O <= 1'b0;
      CMD_OPCODE_O <= '0;
    end else begin
      CMD_VALID_O  <= ev & ~fx & (~in_init | is_status);
      CMD_REJECT_O <= ev & ~fx & in_init & ~is_status;
      if (ev) begin
        CMD_OPCODE_O <= opc;
      end
    end
  end

  // ****************************************
  // status and power-up pin settings
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (rst_all) begin
      INIT_DONE_O  <= 1'b0;
      WIP_O        <= 1'b1;
      FLAG_READY_O <= 1'b1;
      PAUSE_EN_O   <= 1'b1;
      HW_RST_EN_O  <= 1'b0;
      DRIVE_O      <= DRIVE_DEFAULT;
    end else begin
      INIT_DONE_O  <= (state_r == ST_READY);
      WIP_O        <= in_init | PE_BUSY_I;
      FLAG_READY_O <= ~PE_BUSY_I;
      if (in_init) begin
        PAUSE_EN_O  <= 1'b1;
        HW_RST_EN_O <= 1'b0;
        DRIVE_O     <= DRIVE_DEFAULT;
      end else begin
        PAUSE_EN_O  <= NVCFG_I.pause_en;
        HW_RST_EN_O <= NVCFG_I.rst_pin_en;
        DRIVE_O     <= NVCFG_I.drive;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (rst_all) begin
      WEL_O  <= 1'b0;
      LOCK_O <= '0;
    end else if (in_init | hw_go) begin
      WEL_O  <= 1'b0;
      LOCK_O <= '0;
    end else begin
      if (WEL_SET_I) begin
        WEL_O <= 1'b1;
      end
      if (LOCK_WR_I) begin
        LOCK_O <= LOCK_I;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (rst_all);

  property p_conf_keep;
    ev & ~in_init & XIP_ACTIVE_O & ~fx & conf_ok & ~conf & ~hw_go |=> XIP_ACTIVE_O;
  endproperty
  a_conf_keep: assert property (p_conf_keep) else $error("confirm 0 dropped in-place mode");

  property p_conf_exit;
    ev & ~in_init & XIP_ACTIVE_O & ~fx & conf_ok & conf & ~hw_go |=> ~XIP_ACTIVE_O & VCFG_XIP_O;
  endproperty
  a_conf_exit: assert property (p_conf_exit) else $error("confirm 1 did not end in-place mode");

  property p_forced;
    ev & fx & XIP_ACTIVE_O & ~hw_go |=> ~XIP_ACTIVE_O & FORCED_EXIT_O & VCFG_XIP_O & (state_r == ST_READY);
  endproperty
  a_forced: assert property (p_forced) else $error("forced exit misbehaved");

  property p_por;
    @(posedge REF_CLK_I) disable iff (RST_I)
      por_s2_r |=> (state_r == ST_OFF) & ~INIT_DONE_O & ~CMD_VALID_O & ~XIP_ACTIVE_O;
  endproperty
  a_por: assert property (p_por) else $error("logic active below power-on threshold");

  property p_init_reject;
    ev & in_init & ~fx & ~is_status |=> CMD_REJECT_O & ~CMD_VALID_O;
  endproperty
  a_init_reject: assert property (p_init_reject) else $error("command accepted during init");

  property p_clear;
    $rose(INIT_DONE_O) |-> ~WEL_O & (LOCK_O == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("latches not clear after power-up");

  property p_flag;
    PE_BUSY_I & ~in_init |=> ~FLAG_READY_O & WIP_O;
  endproperty
  a_flag: assert property (p_flag) else $error("busy not reported");

  property p_wip;
    (state_r == ST_INIT) |=> WIP_O & ~INIT_DONE_O;
  endproperty
  a_wip: assert property (p_wip) else $error("write-in-progress low during init");

  property p_init_len;
    (state_r == ST_INIT) & (tmr_r == TMR_W'(PWRUP_CYCLES - 1)) |=> ##1 INIT_DONE_O;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init overran access time");

  property p_proto;
    (state_r == ST_OFF) |=> PROTO_O == $past(NVCFG_I.proto);
  endproperty
  a_proto: assert property (p_proto) else $error("protocol not taken from config");

  property p_pins;
    (state_r != ST_READY) |=> PAUSE_EN_O & ~HW_RST_EN_O & (DRIVE_O == DRIVE_DEFAULT);
  endproperty
  a_pins: assert property (p_pins) else $error("pin settings wrong during init");

  property p_hw_quad;
    ~hwr_s2_r & (PROTO_O == PROTO_QIO) & ~cs_s2_r & XIP_ACTIVE_O |=> XIP_ACTIVE_O;
  endproperty
  a_hw_quad: assert property (p_hw_quad) else $error("quad reset acted while selected");

  property p_hw;
    hw_go |=> (XIP_ACTIVE_O == $past(NVCFG_I.xip_boot)) & ~WEL_O;
  endproperty
  a_hw: assert property (p_hw) else $error("reset pin did not restore state");

  c_enter: cover property (~XIP_ACTIVE_O ##1 XIP_ACTIVE_O);
  c_forced: cover property (FORCED_EXIT_O);
  c_ready: cover property ($rose(INIT_DONE_O));
  c_reject: cover property (CMD_REJECT_O);

endmodule
`default_nettype wire

/* src/xip_link_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module xip_link_capture (
  input  wire logic           spi_clk_i,
  input  wire logic           cs_n_i,
  input  wire logic           rst_i,
  input  wire logic [3:0]     dq_i,
  output var  xip_pkg::frame_s frame_o,
  output logic                tog_o
);
  import xip_pkg::*;

  logic [LEN_W-1:0] cnt_r;

  // ****************************************
  // edge count inside the frame
  // ****************************************
  // select high clears the count with no link edge, the clock may stand still
  always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_r <= '0;
    end else if (cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ****************************************
  // frame record, held after select rises
  // ****************************************
  always_ff @(posedge spi_clk_i) begin
    frame_o.len      <= (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
    frame_o.all_ones <= ((cnt_r == '0) | frame_o.all_ones) & dq_i[DQ_CONFIRM] & dq_i[DQ_HOLD];
    if (cnt_r < LEN_W'(FRAME_DEPTH)) begin
      frame_o.dq[cnt_r] <= dq_i;
    end
  end

  // toggles once per frame that saw an edge; zero-edge frames are not reported
  always_ff @(posedge spi_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_o <= 1'b0;
    end else if (cnt_r == '0) begin
      tog_o <= ~tog_o;
    end
  end

endmodule
`default_nettype wire

/* src/xip_pkg.sv */
`default_nettype none
package xip_pkg;

  // ****************************************
  // constants
  // ****************************************
  localparam int FRAME_DEPTH = 48;
  localparam int LEN_W       = 6;
  localparam int ADDR_BYTES  = 3;
  localparam int PWRUP_US    = 300;
  localparam int CLK_MHZ     = 200;
  localparam int PWRUP_CYC   = PWRUP_US * CLK_MHZ;
  localparam int TMR_W       = 17;
  localparam int DQ_CONFIRM  = 0;
  localparam int DQ_HOLD     = 3;
  localparam int EXIT_CNT    = 6;

  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_RD_FLAG   = 8'h70;
  localparam logic [7:0] OP_FREAD_EXT = 8'h0b;
  localparam logic [7:0] OP_FREAD_DIO = 8'hbb;
  localparam logic [7:0] OP_FREAD_QIO = 8'heb;

  localparam logic       CONFIRM_EXIT  = 1'b1;
  localparam logic       VCFG_XIP_OFF  = 1'b1;
  localparam logic [2:0] DRIVE_DEFAULT = 3'h7;

  localparam logic [LEN_W-1:0] EXIT_LEN [EXIT_CNT] = '{6'h07, 6'h09, 6'h0d, 6'h11, 6'h19, 6'h21};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {PROTO_EXT, PROTO_DIO, PROTO_QIO} proto_e;

  typedef struct packed {
    proto_e     proto;
    logic       xip_boot;
    logic [2:0] drive;
    logic       pause_en;
    logic       rst_pin_en;
  } nvcfg_s;

  typedef struct packed {
    logic       write_lock;
    logic       lock_down;
  } lock_s;

  typedef struct packed {
    logic [LEN_W-1:0]            len;
    logic                        all_ones;
    logic [FRAME_DEPTH-1:0][3:0] dq;
  } frame_s;

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [LEN_W-1:0] clk_per_byte(input proto_e p);
    case (p)
      PROTO_DIO: return 6'h04;
      PROTO_QIO: return 6'h02;
      default:   return 6'h08;
    endcase
  endfunction

  function automatic logic [7:0] fread_op(input proto_e p);
    case (p)
      PROTO_DIO: return OP_FREAD_DIO;
      PROTO_QIO: return OP_FREAD_QIO;
      default:   return OP_FREAD_EXT;
    endcase
  endfunction

  function automatic logic [LEN_W-1:0] dummy_idx(input proto_e p, input logic xip);
    logic [LEN_W-1:0] c;
    c = clk_per_byte(p);
    return xip ? LEN_W'(ADDR_BYTES * c) : LEN_W'((ADDR_BYTES + 1) * c);
  endfunction

  function automatic logic [7:0] opcode_of(input frame_s f, input proto_e p);
    logic [7:0] b;
    b = '0;
    for (int e = 0; e < 8; e++) begin
      case (p)
        PROTO_DIO: if (e < 4) b = {b[5:0], f.dq[e][1:0]};
        PROTO_QIO: if (e < 2) b = {b[3:0], f.dq[e]};
        default:   b = {b[6:0], f.dq[e][DQ_CONFIRM]};
      endcase
    end
    return b;
  endfunction

  function automatic logic is_exit_len(input logic [LEN_W-1:0] n);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < EXIT_CNT; i++) begin
      hit = hit | (n == EXIT_LEN[i]);
    end
    return hit;
  endfunction

endpackage
`default_nettype wire

/* verification/host_spi_model.sv */
`timescale 1ns/1ps
`default_nettype none
// **********
// host side of the link
// **********
module host_spi_model (
  output logic       spi_clk_o,
  output logic       cs_n_o,
  output logic [3:0] dq_o
);
  initial begin
    spi_clk_o = 1'b0;
    cs_n_o    = 1'b0;
    dq_o      = 4'h5;
    // select follows supply up: a real edge that clears the frame counter, unknown at power-on
    #1 cs_n_o = 1'b1;
  end

  // clock runs only inside a frame; released lanes show the inverse, never a stale value
  task automatic frame(input int n, input logic [3:0] d [48]);
    cs_n_o = 1'b0;
    for (int k = 0; k < n; k++) begin
      #7 dq_o = d[k];
      #8 spi_clk_o = 1'b1;
      #15 spi_clk_o = 1'b0;
    end
    #10 cs_n_o = 1'b1;
    dq_o = ~dq_o;
    #(60 + $urandom_range(60));
  endtask

  // select held with no clock, to park the device selected
  task automatic select(input logic v);
    #3 cs_n_o = v;
    #40;
  endtask
endmodule
`default_nettype wire

/* verification/xip_exit_and_powerup_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module xip_exit_and_powerup_control_tb;
  import xip_pkg::*;
  // **********
  // signals
  // **********
  localparam int unsigned PWR = 1000;
  logic ref_clk = 1'b0, rst = 1'b0, por = 1'b0, hw_rst_n = 1'b1, vcfg_wr = 1'b0, vcfg_xip = 1'b1;
  logic pe_busy = 1'b0, wel_set = 1'b0, lock_wr = 1'b0;
  logic spi_clk, cs_n, xip_act, vcfg_xip_o, write_in_progress, wel, flag_rdy, init_done, pause_en, hw_rst_en;
  logic cmd_valid, cmd_reject, forced;
  logic [3:0] dq;
  logic [2:0] drive;
  logic [7:0] cmd_op;
  nvcfg_s     nvcfg;
  lock_s      lock_in = 2'h0, lock_out;
  proto_e     proto_out, cur;
  int         n_errors = 0, checks = 0;
  logic [11:0] notes [$];
  logic [11:0] exp_note;
  logic [3:0] d [48];

  always #2.5 ref_clk = ~ref_clk;

  xip_exit_and_powerup_control #(.PWRUP_CYCLES(PWR)) i_xip_exit_and_powerup_control (
    .REF_CLK_I(ref_clk), .RST_I(rst), .POR_I(por), .SPI_CLK_I(spi_clk), .CS_N_I(cs_n), .DQ_I(dq),
    .HW_RST_N_I(hw_rst_n), .NVCFG_I(nvcfg), .VCFG_WR_I(vcfg_wr), .VCFG_XIP_I(vcfg_xip),
    .PE_BUSY_I(pe_busy), .WEL_SET_I(wel_set), .LOCK_WR_I(lock_wr), .LOCK_I(lock_in),
    .XIP_ACTIVE_O(xip_act), .VCFG_XIP_O(vcfg_xip_o), .PROTO_O(proto_out), .WIP_O(write_in_progress), .WEL_O(wel),
    .LOCK_O(lock_out), .FLAG_READY_O(flag_rdy), .INIT_DONE_O(init_done), .PAUSE_EN_O(pause_en),
    .HW_RST_EN_O(hw_rst_en), .DRIVE_O(drive), .CMD_VALID_O(cmd_valid), .CMD_OPCODE_O(cmd_op),
    .CMD_REJECT_O(cmd_reject), .FORCED_EXIT_O(forced));

  host_spi_model i_host_spi_model (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .dq_o(dq));

  // **********
  // result watcher: every pulse consumes the oldest note
  // **********
  always @(negedge ref_clk) begin
    if ((cmd_valid | cmd_reject | forced) === 1'b1) begin
      if (notes.size() == 0) `CHK({cmd_valid, cmd_reject, forced}, 3'h0)
      else begin
        // pop once: the compare macro reads its expected value twice
        exp_note = notes.pop_front();
        `CHK({cmd_valid, cmd_reject, forced, xip_act, cmd_valid ? cmd_op : 8'h00}, exp_note)
      end
    end
  end

  // **********
  // tasks
  // **********
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic note(input logic [3:0] f, input logic [7:0] op);
    notes.push_back({f, op});
  endtask

  function automatic logic [7:0] fop(input proto_e p);
    return p == PROTO_QIO ? OP_FREAD_QIO : p == PROTO_DIO ? OP_FREAD_DIO : OP_FREAD_EXT;
  endfunction

  // lengths chosen so no random frame can land on a forced-exit length
  task automatic send(input proto_e p, input logic has_op, input logic [7:0] op, input logic cb);
    int w, cpb, idx;
    logic [3:0] m;
    logic [7:0] t;
    w = (p == PROTO_QIO) ? 4 : (p == PROTO_DIO) ? 2 : 1;
    cpb = 8 / w;
    m = 4'((1 << w) - 1);
    idx = has_op ? 4 * cpb : 3 * cpb;
    foreach (d[k]) d[k] = 4'($urandom);
    for (int e = 0; e < cpb && has_op; e++) begin
      t = op >> (8 - w * (e + 1));
      d[e] = (d[e] & ~m) | (t[3:0] & m);
    end
    d[idx][DQ_CONFIRM] = cb;
    i_host_spi_model.frame(idx + cpb + 2, d);
    tick(8);
  endtask

  task automatic enter(input proto_e p);
    vcfg_xip = 1'b0;
    vcfg_wr = 1'b1;
    tick(1);
    vcfg_wr = 1'b0;
    tick(2);
    note(4'h9, fop(p));
    send(p, 1'b1, fop(p), 1'b0);
  endtask

  task automatic hw_pulse();
    hw_rst_n = 1'b0;
    tick(6);
    hw_rst_n = 1'b1;
    tick(4);
  endtask

  task automatic do_reset(input proto_e p);
    nvcfg = '{proto: p, xip_boot: 1'b0, drive: 3'($urandom), pause_en: 1'($urandom), rst_pin_en: 1'b1};
    rst = 1'b1;
    tick(16);
    rst = 1'b0;
    wel_set = 1'b1;
    tick(1);
    wel_set = 1'b0;
    tick(2);
    `CHK({write_in_progress, init_done, pause_en, hw_rst_en, drive, xip_act, wel}, {4'ha, DRIVE_DEFAULT, 2'b00})
  endtask

  task automatic wait_init(input proto_e p);
    int c;
    c = 0;
    while (init_done !== 1'b1 && c < PWR + 16) begin
      tick(1);
      c++;
    end
    `CHK({init_done, write_in_progress, wel, lock_out, hw_rst_en, proto_out}, {5'h10, 1'b1, p})
    `CHK({pause_en, drive}, {nvcfg.pause_en, nvcfg.drive})
  endtask

  task automatic summarize();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // **********
  // sequence
  // **********
  initial begin
    void'($urandom(32'h0894));
    // let every process start, so the async clears in the link logic see the reset edge
    #1;
    for (int i = 0; i < EXIT_CNT; i++) begin
      cur = proto_e'(i % 3);
      do_reset(cur);
      if (cur == PROTO_EXT) begin
        tick(4);
        note(4'h4, 8'h00);
        send(cur, 1'b1, 8'h9f, 1'b0);
        note(4'h8, OP_RD_STATUS);
        send(cur, 1'b1, OP_RD_STATUS, 1'b0);
        note(4'h8, OP_RD_FLAG);
        send(cur, 1'b1, OP_RD_FLAG, 1'b0);
      end
      wait_init(cur);
      enter(cur);
      note(4'h9, fop(cur));
      send(cur, 1'b0, 8'h00, 1'b0);
      note(4'h8, fop(cur));
      send(cur, 1'b0, 8'h00, 1'b1);
      `CHK(vcfg_xip_o, VCFG_XIP_OFF)
      enter(cur);
      pe_busy = 1'b1;
      tick(2);
      `CHK({flag_rdy, write_in_progress}, 2'b01)
      foreach (d[k]) d[k] = 4'hf;
      note(4'h2, 8'h00);
      i_host_spi_model.frame(int'(EXIT_LEN[i]), d);
      tick(8);
      `CHK({flag_rdy, write_in_progress, vcfg_xip_o}, 3'b011)
      pe_busy = 1'b0;
      tick(2);
      `CHK({flag_rdy, write_in_progress}, 2'b10)
      note(4'h8, 8'h66);
      send(cur, 1'b1, 8'h66, 1'b0);
      note(4'h8, 8'h99);
      send(cur, 1'b1, 8'h99, 1'b0);
      enter(cur);
      lock_in = lock_s'(2'($urandom));
      wel_set = 1'b1;
      lock_wr = 1'b1;
      tick(1);
      wel_set = 1'b0;
      lock_wr = 1'b0;
      tick(1);
      `CHK({wel, lock_out}, {1'b1, lock_in})
      if (cur == PROTO_QIO) begin
        i_host_spi_model.select(1'b0);
        hw_pulse();
        `CHK(xip_act, 1'b1)
        i_host_spi_model.select(1'b1);
        tick(6);
      end
      hw_pulse();
      `CHK({xip_act, vcfg_xip_o, wel, lock_out}, 5'h08)
    end
    por = 1'b1;
    tick(4);
    send(PROTO_EXT, 1'b1, OP_RD_STATUS, 1'b0);
    `CHK({write_in_progress, init_done, xip_act}, 3'b100)
    por = 1'b0;
    `CHK(notes.size(), 0)
    summarize();
  end

  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
